// >>> hw/nec_pkg.sv
// Package with register map, field positions and constants of the NAND ECC engine control.
package nec_pkg;
    localparam logic [7:0]  NEC_OFF_CONTROL  = 8'h00;
    localparam logic [7:0]  NEC_OFF_RESULT   = 8'h04;
    localparam logic [7:0]  NEC_OFF_PARITY_A = 8'h08;
    localparam logic [7:0]  NEC_OFF_PARITY_B = 8'h0C;
    localparam logic [7:0]  NEC_OFF_PARITY_C = 8'h10;
    localparam logic [7:0]  NEC_OFF_STATUS   = 8'h14;
    localparam int          NEC_BIT_ENABLE   = 0;
    localparam int          NEC_BIT_ENGINE_RESET     = 1;
    localparam int          NEC_BIT_ALGO     = 2;
    localparam int          NEC_BIT_PHASE    = 3;
    localparam int          NEC_BIT_PLOADED  = 4;
    localparam int          NEC_BIT_ENCDONE  = 2;
    localparam int          NEC_ERROR_COUNT_LSB     = 29;
    localparam logic [31:0] NEC_CONTROL_RST  = 32'h0000_0000;
    localparam logic [71:0] NEC_PARITY_RST   = 72'h00_0000_0000_0000_0000;
    localparam int          NEC_BLOCK_BYTES  = 512;
    localparam int          NEC_SYMBOLS      = 8;
    localparam int          NEC_SYM_W        = 9;
    localparam logic [8:0]  NEC_RS_POLY      = 9'h011;
    localparam logic [8:0]  NEC_RS_GEN [8]   = '{9'h001, 9'h002, 9'h004, 9'h008,
                                                 9'h010, 9'h020, 9'h040, 9'h080};
endpackage

// >>> hw/nec_compute.sv
// Hamming and Reed-Solomon parity computation over the NAND data stream.
`timescale 1ns/10ps
`default_nettype none
module nec_compute
    import nec_pkg::*;
#(
    parameter int BLOCK_BYTES = NEC_BLOCK_BYTES
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        engine_clear,
    input  wire logic        feed,
    input  wire logic [7:0]  feed_data,
    input  wire logic        algorithm_select,
    input  wire logic        rs_phase_select,
    input  wire logic        sw_wr,
    input  wire logic [1:0]  sw_idx,
    input  wire logic [31:0] sw_word,
    output logic      [23:0] ham_result,
    output logic      [71:0] parity_flat,
    output logic             block_done
);
    // ****************************************
    // Galois field helper.
    // ****************************************
    function automatic logic [8:0] gf_mul(input logic [8:0] a, input logic [8:0] b);
        logic [8:0] r;
        logic [8:0] x;
        r = '0;
        x = a;
        for (int i = 0; i < 9; i++) begin
            if (b[i]) begin
                r = r ^ x;
            end
            x = x[8] ? ({x[7:0], 1'b0} ^ NEC_RS_POLY) : {x[7:0], 1'b0};
        end
        return r;
    endfunction

    // ****************************************
    // Byte position and Hamming accumulation.
    // ****************************************
    logic [8:0]  count_reg;
    logic [8:0]  line_even_reg;
    logic [8:0]  line_odd_reg;
    logic [5:0]  col_reg;
    logic        byte_par;
    logic [5:0]  col_next;
    logic        ham_feed;
    logic        rs_feed;
    logic [71:0] lfsr_next;
    logic [8:0]  fb;

    assign byte_par = ^feed_data;
    assign col_next = {^feed_data[7:4], ^feed_data[3:0],
                       ^{feed_data[7], feed_data[6], feed_data[3], feed_data[2]},
                       ^{feed_data[5], feed_data[4], feed_data[1], feed_data[0]},
                       ^{feed_data[7], feed_data[5], feed_data[3], feed_data[1]},
                       ^{feed_data[6], feed_data[4], feed_data[2], feed_data[0]}};
    assign ham_feed = feed & ~algorithm_select;
    assign rs_feed  = feed & algorithm_select & rs_phase_select;

    always_ff @(posedge mclk) begin
        if (rst || engine_clear) begin
            count_reg <= '0;
        end else if (feed) begin
            count_reg <= count_reg + 9'h001;
        end
    end

    // Hamming state survives system reset and is cleared only by the engine reset.
    always_ff @(posedge mclk) begin
        if (engine_clear) begin
            line_even_reg <= '0;
            line_odd_reg  <= '0;
            col_reg       <= '0;
        end else if (ham_feed) begin
            line_even_reg <= line_even_reg ^ ({9{byte_par}} & ~count_reg);
            line_odd_reg  <= line_odd_reg ^ ({9{byte_par}} & count_reg);
            col_reg       <= col_reg ^ col_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 9; g++) begin : g_line
            assign ham_result[2*g]   = line_even_reg[g];
            assign ham_result[2*g+1] = line_odd_reg[g];
        end
    endgenerate
    assign ham_result[23:18] = col_reg;

    // ****************************************
    // Reed-Solomon encoder shift register.
    // ****************************************
    assign fb = {1'b0, feed_data} ^ parity_flat[71:63];

    generate
        for (g = 0; g < NEC_SYMBOLS; g++) begin : g_sym
            if (g < NEC_SYMBOLS - 1) begin : g_mid
                assign lfsr_next[71-9*g -: 9] = parity_flat[62-9*g -: 9] ^ gf_mul(fb, NEC_RS_GEN[g]);
            end else begin : g_last
                assign lfsr_next[8:0] = gf_mul(fb, NEC_RS_GEN[g]);
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (rst || engine_clear) begin
            parity_flat <= NEC_PARITY_RST;
        end else if (sw_wr) begin
            case (sw_idx)
                2'h0:    parity_flat[31:0]  <= sw_word;
                2'h1:    parity_flat[63:32] <= sw_word;
                2'h2:    parity_flat[71:64] <= sw_word[7:0];
                default: parity_flat        <= parity_flat;
            endcase
        end else if (rs_feed) begin
            parity_flat <= lfsr_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || engine_clear) begin
            block_done <= 1'b0;
        end else begin
            block_done <= rs_feed && (count_reg == 9'(BLOCK_BYTES - 1));
        end
    end
endmodule
`default_nettype wire

// >>> hw/nec_engine_control.sv
// APB register block and stream steering of the NAND ECC engine control.
//
// Overview of operation
// - Parity-ready write pulses, reads as zero.
// - Control bit 3 selects encode or decode.
// - Control bit 2 selects Hamming or Reed-Solomon.
// - Engine-reset bit pulses, self-clears, reads zero.
// - Control bit 0 enables ECC calculation.
// - Control resets to zero; bits 31:5 zero.
// - Result holds three Hamming bytes.
// - Result bits 31:24 read zero.
// - Result cleared only by engine reset.
// - Parity cleared by system and engine reset.
// - Eight 9-bit symbols packed in three registers.
// - Encoder writes parity; encode-done flag signals.
// - Engine reset clears error count field.
// - ECC applies only to NAND banks.
`timescale 1ns/10ps
`default_nettype none
module nec_engine_control
    import nec_pkg::*;
#(
    parameter int BLOCK_BYTES = NEC_BLOCK_BYTES,
    parameter int BANKS       = 4
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             nand_valid,
    input  wire logic [7:0]       nand_data,
    input  wire logic [1:0]       nand_bank,
    input  wire logic [BANKS-1:0] bank_is_nand,
    input  wire logic             err_count_valid,
    input  wire logic [2:0]       err_count_in,
    output logic                  parity_loaded_strobe,
    output logic                  engine_reset,
    output logic                  ecc_enable,
    output logic                  algorithm_select,
    output logic                  rs_phase_select
);
    // ****************************************
    // Bus decode.
    // ****************************************
    logic        access;
    logic        done;
    logic        wr;
    logic        mapped;
    logic [31:0] mask;
    logic [31:0] rd_mux;
    logic [23:0] ham_result;
    logic [71:0] parity_flat;
    logic        block_done;
    logic        feed;
    logic        sw_wr;
    logic [1:0]  sw_idx;
    logic [31:0] sw_word;
    logic        encode_done_reg;
    logic [2:0]  error_count_reg;

    assign access = psel & penable;
    assign done   = access & pready;
    assign wr     = done & pwrite;
    assign mapped = (paddr == NEC_OFF_CONTROL) || (paddr == NEC_OFF_RESULT)
                 || (paddr == NEC_OFF_PARITY_A) || (paddr == NEC_OFF_PARITY_B)
                 || (paddr == NEC_OFF_PARITY_C) || (paddr == NEC_OFF_STATUS);
    assign mask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    always_comb begin
        case (paddr)
            NEC_OFF_CONTROL:  rd_mux = {28'h0000000, rs_phase_select, algorithm_select,
                                        1'b0, ecc_enable};
            NEC_OFF_RESULT:   rd_mux = {8'h00, ham_result};
            NEC_OFF_PARITY_A: rd_mux = parity_flat[31:0];
            NEC_OFF_PARITY_B: rd_mux = parity_flat[63:32];
            NEC_OFF_PARITY_C: rd_mux = {24'h000000, parity_flat[71:64]};
            NEC_OFF_STATUS:   rd_mux = {error_count_reg, 26'h0000000, encode_done_reg, 2'h0};
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    // One wait state: pready rises in the second access cycle.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= access & ~pready;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~mapped;
        end else begin
            pslverr <= 1'b0;
        end
    end

    // ****************************************
    // Control register.
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            ecc_enable       <= NEC_CONTROL_RST[NEC_BIT_ENABLE];
            algorithm_select <= NEC_CONTROL_RST[NEC_BIT_ALGO];
            rs_phase_select  <= NEC_CONTROL_RST[NEC_BIT_PHASE];
        end else if (wr && paddr == NEC_OFF_CONTROL && pstrb[0]) begin
            ecc_enable       <= pwdata[NEC_BIT_ENABLE];
            algorithm_select <= pwdata[NEC_BIT_ALGO];
            rs_phase_select  <= pwdata[NEC_BIT_PHASE];
        end
    end

    // Self-clearing strobes: high for exactly one cycle after the write completes.
    always_ff @(posedge mclk) begin
        if (rst) begin
            engine_reset         <= 1'b0;
            parity_loaded_strobe <= 1'b0;
        end else begin
            engine_reset         <= wr && paddr == NEC_OFF_CONTROL && pstrb[0]
                                 && pwdata[NEC_BIT_ENGINE_RESET];
            parity_loaded_strobe <= wr && paddr == NEC_OFF_CONTROL && pstrb[0]
                                 && pwdata[NEC_BIT_PLOADED];
        end
    end

    // ****************************************
    // Parity writes and stream steering.
    // ****************************************
    always_comb begin
        sw_wr  = 1'b0;
        sw_idx = 2'h0;
        case (paddr)
            NEC_OFF_PARITY_A: begin
                sw_wr  = wr;
                sw_idx = 2'h0;
            end
            NEC_OFF_PARITY_B: begin
                sw_wr  = wr;
                sw_idx = 2'h1;
            end
            NEC_OFF_PARITY_C: begin
                sw_wr  = wr;
                sw_idx = 2'h2;
            end
            default: begin
                sw_wr  = 1'b0;
                sw_idx = 2'h0;
            end
        endcase
    end
    assign sw_word = (rd_mux & ~mask) | (pwdata & mask);

    assign feed = ecc_enable & nand_valid & bank_is_nand[nand_bank];

    nec_compute #(
        .BLOCK_BYTES (BLOCK_BYTES)
    ) u_compute (
        .mclk             (mclk),
        .rst              (rst),
        .engine_clear     (engine_reset),
        .feed             (feed),
        .feed_data        (nand_data),
        .algorithm_select (algorithm_select),
        .rs_phase_select  (rs_phase_select),
        .sw_wr            (sw_wr),
        .sw_idx           (sw_idx),
        .sw_word          (sw_word),
        .ham_result       (ham_result),
        .parity_flat      (parity_flat),
        .block_done       (block_done)
    );

    // ****************************************
    // Status register.
    // ****************************************
    always_ff @(posedge mclk) begin
        if (rst || engine_reset) begin
            encode_done_reg <= 1'b0;
        end else if (block_done) begin
            encode_done_reg <= 1'b1;
        end else if (wr && paddr == NEC_OFF_STATUS && pstrb[0] && !pwdata[NEC_BIT_ENCDONE]) begin
            encode_done_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || engine_reset) begin
            error_count_reg <= 3'h0;
        end else if (err_count_valid) begin
            error_count_reg <= err_count_in;
        end
    end
endmodule
`default_nettype wire

// >>> verification/nec_checker.sv
// Port assertions of the NAND ECC engine control.
`timescale 1ns/10ps
`default_nettype none
// ****
// Checker.
// ****
module nec_checker (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        parity_loaded_strobe,
    input wire logic        engine_reset,
    input wire logic        ecc_enable,
    input wire logic        algorithm_select,
    input wire logic        rs_phase_select
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    logic ctl_wr;
    logic ctl_rd;
    assign ctl_wr = pready && pwrite && paddr == 8'h00;
    assign ctl_rd = pready && !pwrite;
    property p_parity_loaded_strobe;
        parity_loaded_strobe |-> $past(ctl_wr && pwdata[4]) ##1 !parity_loaded_strobe;
    endproperty
    a_parity_loaded_strobe: assert property (p_parity_loaded_strobe) else $error("bad parity strobe");
    property p_engine_reset;
        ctl_wr && pwdata[1] |=> engine_reset ##1 !engine_reset;
    endproperty
    a_engine_reset: assert property (p_engine_reset) else $error("bad engine strobe");
    property p_ctl;
        ctl_wr |=> {rs_phase_select, algorithm_select, ecc_enable}
            == {$past(pwdata[3]), $past(pwdata[2]), $past(pwdata[0])};
    endproperty
    a_ctl: assert property (p_ctl) else $error("control levels wrong");
    property p_rst;
        $fell(rst) |-> !pready && !ecc_enable && !algorithm_select && !rs_phase_select
            && !engine_reset && !parity_loaded_strobe;
    endproperty
    a_rst: assert property (p_rst) else $error("not cleared by reset");
    property p_rdz;
        ctl_rd && paddr == 8'h00 |-> prdata[31:4] == 28'h0 && !prdata[1];
    endproperty
    a_rdz: assert property (p_rdz) else $error("control reads nonzero");
    property p_res;
        ctl_rd && paddr == 8'h04 |-> prdata[31:24] == 8'h00;
    endproperty
    a_res: assert property (p_res) else $error("result top nonzero");
    property p_parc;
        ctl_rd && paddr == 8'h10 |-> prdata[31:8] == 24'h0;
    endproperty
    a_parc: assert property (p_parc) else $error("parity c top nonzero");
    property p_unmap;
        pready && paddr > 8'h14 |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
endmodule
bind nec_engine_control nec_checker nec_checker_inst (
    .mclk, .rst, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .parity_loaded_strobe, .engine_reset, .ecc_enable, .algorithm_select, .rs_phase_select
);
`default_nettype wire

// >>> verification/nec_nand_model.sv
// Byte stream source on the NAND bank side of the engine.
`timescale 1ns/10ps
`default_nettype none
// ****
// NAND stream model.
// ****
module nec_nand_model (
    input  wire logic       mclk,
    input  wire logic       go,
    input  wire logic [9:0] count,
    input  wire logic [1:0] bank,
    output logic            nand_valid,
    output logic [7:0]      nand_data,
    output logic [1:0]      nand_bank
);
    logic [9:0] left_reg = 10'h000;
    initial begin
        nand_valid = 1'b0;
        nand_data = 8'h00;
        nand_bank = 2'b00;
    end
    // Sends count bytes one a cycle in order; idle lines toggle.
    always @(posedge mclk) begin
        if (go || left_reg > 10'h001) begin
            left_reg <= go ? count : left_reg - 10'h001;
            nand_valid <= 1'b1;
            nand_data <= go ? 8'hA5 : nand_data + 8'h3B;
            nand_bank <= go ? bank : nand_bank;
        end else begin
            left_reg <= 10'h000;
            nand_valid <= 1'b0;
            nand_data <= ~nand_data;
            nand_bank <= ~nand_bank;
        end
    end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench of the NAND ECC engine control.
`timescale 1ns/10ps
`default_nettype none
// ****
// Bench top.
// ****
module testbench;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, h;
    logic        pready, pslverr, err, prs, ers, nand_valid;
    logic        ecc_enable, algorithm_select, rs_phase_select;
    logic        go = 1'b0;
    logic [9:0]  cnt = 10'h000;
    logic [1:0]  bnk = 2'b00;
    logic [1:0]  nand_bank;
    logic [7:0]  nand_data;
    logic        ecv = 1'b0;
    logic [2:0]  ecin = 3'h0;
    int          fails = 0;
    int          n_tests = 0;
    int          n_parity_loaded_strobe = 0;
    always #4 mclk = ~mclk;
    always @(posedge mclk) n_parity_loaded_strobe <= n_parity_loaded_strobe + (prs === 1'b1);
    nec_engine_control nec_engine_control_inst (
        .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata,
        .pready, .pslverr, .nand_valid, .nand_data, .nand_bank, .bank_is_nand(4'h5),
        .err_count_valid(ecv), .err_count_in(ecin), .parity_loaded_strobe(prs),
        .engine_reset(ers), .ecc_enable, .algorithm_select, .rs_phase_select
    );
    nec_nand_model nec_nand_model_inst (
        .mclk, .go, .count(cnt), .bank(bnk), .nand_valid, .nand_data, .nand_bank
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        chk({31'h0, pready}, 32'h1, "no ready");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "read");
    endtask
    task automatic feed(input logic [9:0] n, input logic [1:0] b);
        @(posedge mclk);
        go <= 1'b1;
        cnt <= n;
        bnk <= b;
        @(posedge mclk);
        go <= 1'b0;
        repeat (600) begin
            @(posedge mclk);
            if (nand_valid !== 1'b1) break;
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic t_control();
        int p;
        p = n_parity_loaded_strobe;
        apb(1'b1, 8'h00, 32'hFFFF_FFFF);
        rdchk(8'h00, 32'h0000_000D);
        chk({29'h0, rs_phase_select, algorithm_select, ecc_enable}, 32'h7, "lv");
        chk(32'(n_parity_loaded_strobe - p), 32'h1, "strobe");
        apb(1'b1, 8'h00, 32'h0);
        @(negedge mclk);
        chk({29'h0, rs_phase_select, algorithm_select, ecc_enable}, 32'h0, "lv");
    endtask
    task automatic t_parity();
        apb(1'b1, 8'h08, 32'hFFFF_FFFF);
        apb(1'b1, 8'h0C, 32'h1234_5678);
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        rdchk(8'h0C, 32'h1234_5678);
        rdchk(8'h10, 32'h0000_00FF);
        apb(1'b1, 8'h00, 32'h0000_0002);
        rdchk(8'h08, 32'h0);
    endtask
    task automatic t_hamming();
        rdchk(8'h04, 32'h0);
        apb(1'b1, 8'h00, 32'h0000_0001);
        feed(10'h010, 2'h1);
        rdchk(8'h04, 32'h0);
        feed(10'h010, 2'h0);
        apb(1'b0, 8'h04, 32'h0);
        h = rd;
        chk({31'h0, h != 32'h0}, 32'h1, "no result");
        apb(1'b1, 8'h00, 32'h0);
        feed(10'h010, 2'h0);
        rdchk(8'h04, h);
        apb(1'b1, 8'h00, 32'h0000_0005);
        apb(1'b1, 8'h0C, 32'h1234_5678);
        feed(10'h010, 2'h0);
        rdchk(8'h0C, 32'h1234_5678);
        rdchk(8'h04, h);
        apb(1'b1, 8'h08, 32'h0000_0100);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rdchk(8'h04, h);
        rdchk(8'h08, 32'h0);
    endtask
    task automatic t_encode();
        apb(1'b1, 8'h00, 32'h0000_000D);
        feed(10'h200, 2'h2);
        apb(1'b0, 8'h08, 32'h0);
        h = rd;
        apb(1'b0, 8'h0C, 32'h0);
        chk({31'h0, (h | rd) != 32'h0}, 32'h1, "no parity");
        rdchk(8'h14, 32'h0000_0004);
        ecv <= 1'b1;
        ecin <= 3'h5;
        @(posedge mclk);
        ecv <= 1'b0;
        rdchk(8'h14, 32'hA000_0004);
        apb(1'b1, 8'h14, 32'h0);
        rdchk(8'h14, 32'hA000_0000);
        apb(1'b1, 8'h00, 32'h0000_0002);
        rdchk(8'h14, 32'h0);
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h1, "no error");
        rdchk(8'h40, 32'h0);
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        rdchk(8'h00, 32'h0);
        rdchk(8'h10, 32'h0);
        t_control();
        t_parity();
        t_hamming();
        t_encode();
        give_verdict();
    end
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
endmodule
`default_nettype wire
